// *** verilog/adc_window_pkg.sv ***
// Constants, types and register map shared by the converter window detector.
package adc_window_pkg;

  // ==========================================================================
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_INPUT_PAIR_CONFIG   = 8'hB8;
  localparam logic [7:0] IDX_RESULT_LOW_BYTE     = 8'hBE;
  localparam logic [7:0] IDX_RESULT_HIGH_BYTE    = 8'hBF;
  localparam logic [7:0] IDX_UPPER_LIMIT_LOW     = 8'hC4;
  localparam logic [7:0] IDX_UPPER_LIMIT_HIGH    = 8'hC5;
  localparam logic [7:0] IDX_LOWER_LIMIT_LOW     = 8'hC6;
  localparam logic [7:0] IDX_LOWER_LIMIT_HIGH    = 8'hC7;
  localparam logic [7:0] IDX_CONTROL             = 8'hE8;

  // ==========================================================================
  // Field positions.
  localparam int CTRL_LEFT_JUSTIFY_BIT = 0;
  localparam int CTRL_WINDOW_MATCH_BIT = 1;
  localparam int PAIR_DIFFERENTIAL_BIT = 0;
  localparam int ADDR_INDEX_LSB        = 2;
  localparam int CODE_W                = 12;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] RST_UPPER_LIMIT_LOW  = 8'hFF;
  localparam logic [7:0] RST_UPPER_LIMIT_HIGH = 8'hFF;
  localparam logic [7:0] RST_LOWER_LIMIT_LOW  = 8'h00;
  localparam logic [7:0] RST_LOWER_LIMIT_HIGH = 8'h00;
  localparam logic [7:0] RST_BYTE_ZERO        = 8'h00;

  // ==========================================================================
  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types.
  typedef struct packed {
    logic              valid;
    logic [CODE_W-1:0] code;
  } conv_type;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_state_type;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } wr_state_type;

  typedef enum logic [8:0] {
    SEL_NONE      = 9'b000000001,
    SEL_PAIR_CFG  = 9'b000000010,
    SEL_RES_LOW   = 9'b000000100,
    SEL_RES_HIGH  = 9'b000001000,
    SEL_UPPER_LOW = 9'b000010000,
    SEL_UPPER_HI  = 9'b000100000,
    SEL_LOWER_LOW = 9'b001000000,
    SEL_LOWER_HI  = 9'b010000000,
    SEL_CONTROL   = 9'b100000000
  } reg_sel_type;

endpackage

// *** verilog/adc_window_detector.sv ***
// Window detector and result formatter of a 12-bit converter, with an AXI4-Lite register slave.
// ==========================================================================
// Functional notes
// - Every finished conversion is compared to the limits without software help.
// - Window match flag is readable for polling and drives an interrupt-capable output.
// - Each 16-bit limit is two separately writable bytes, upper and lower limit.
// - Limit ordering chooses whether matches are inside or outside the range.
// - Right-justified code is Vin*gain/ref times 2^12 single-ended, 2^11 differential.
// - Right-justified high byte: bits 7-4 zero single-ended or sign extension differential, bits 3-0 top result bits.
// - Left-justified: high byte holds top eight bits, low byte top holds the rest.
module adc_window_detector
  import adc_window_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                      I_CLK,
  input  wire logic                      I_NRST,
  input  wire adc_window_pkg::conv_type  I_CONV,
  input  wire logic [ADDR_W-1:0]         I_AWADDR,
  input  wire logic                      I_AWVALID,
  output logic                           O_AWREADY,
  input  wire logic [31:0]               I_WDATA,
  input  wire logic [3:0]                I_WSTRB,
  input  wire logic                      I_WVALID,
  output logic                           O_WREADY,
  output logic [1:0]                     O_BRESP,
  output logic                           O_BVALID,
  input  wire logic                      I_BREADY,
  input  wire logic [ADDR_W-1:0]         I_ARADDR,
  input  wire logic                      I_ARVALID,
  output logic                           O_ARREADY,
  output logic [31:0]                    O_RDATA,
  output logic [1:0]                     O_RRESP,
  output logic                           O_RVALID,
  input  wire logic                      I_RREADY,
  output logic                           O_WINDOW_MATCH
);
  import adc_window_pkg::*;

  // ==========================================================================
  // Helpers.
  function automatic reg_sel_type decode(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = addr[ADDR_INDEX_LSB +: 8];
    if (addr[1:0] != 2'h0) begin
      decode = SEL_NONE;
    end else if (idx == IDX_INPUT_PAIR_CONFIG) begin
      decode = SEL_PAIR_CFG;
    end else if (idx == IDX_RESULT_LOW_BYTE) begin
      decode = SEL_RES_LOW;
    end else if (idx == IDX_RESULT_HIGH_BYTE) begin
      decode = SEL_RES_HIGH;
    end else if (idx == IDX_UPPER_LIMIT_LOW) begin
      decode = SEL_UPPER_LOW;
    end else if (idx == IDX_UPPER_LIMIT_HIGH) begin
      decode = SEL_UPPER_HI;
    end else if (idx == IDX_LOWER_LIMIT_LOW) begin
      decode = SEL_LOWER_LOW;
    end else if (idx == IDX_LOWER_LIMIT_HIGH) begin
      decode = SEL_LOWER_HI;
    end else if (idx == IDX_CONTROL) begin
      decode = SEL_CONTROL;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  // The raw code is already the scaled value; only its placement in the word changes.
  function automatic logic [15:0] format_word(input logic [CODE_W-1:0] code,
                                              input logic               left,
                                              input logic               diff);
    if (left) begin
      format_word = {code, 4'h0};
    end else if (diff) begin
      format_word = {{4{code[CODE_W-1]}}, code};
    end else begin
      format_word = {4'h0, code};
    end
  endfunction

  // Differential words are two's complement, so they compare signed.
  function automatic logic less_than(input logic [15:0] a,
                                     input logic [15:0] b,
                                     input logic        diff);
    if (diff) begin
      less_than = $signed(a) < $signed(b);
    end else begin
      less_than = a < b;
    end
  endfunction

  // ==========================================================================
  // State.
  logic [7:0]        upper_low_ff, nxt_upper_low;
  logic [7:0]        upper_high_ff, nxt_upper_high;
  logic [7:0]        lower_low_ff, nxt_lower_low;
  logic [7:0]        lower_high_ff, nxt_lower_high;
  logic              left_justify_ff, nxt_left_justify;
  logic              differential_ff, nxt_differential;
  logic              match_ff, nxt_match;
  logic [CODE_W-1:0] code_ff, nxt_code;

  wr_state_type      wr_state_ff, nxt_wr_state;
  logic              aw_got_ff, nxt_aw_got;
  logic              w_got_ff, nxt_w_got;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [7:0]        wbyte_ff, nxt_wbyte;
  logic              wlane_ff, nxt_wlane;
  logic              awready_ff, nxt_awready;
  logic              wready_ff, nxt_wready;
  logic              bvalid_ff, nxt_bvalid;
  logic [1:0]        bresp_ff, nxt_bresp;

  rd_state_type      rd_state_ff, nxt_rd_state;
  logic              arready_ff, nxt_arready;
  logic              rvalid_ff, nxt_rvalid;
  logic [31:0]       rdata_ff, nxt_rdata;
  logic [1:0]        rresp_ff, nxt_rresp;

  logic [15:0]       upper_word;
  logic [15:0]       lower_word;
  logic [15:0]       new_word;
  logic [15:0]       cur_word;
  logic              window_hit;
  logic              do_write;
  reg_sel_type       wr_sel;
  reg_sel_type       rd_sel;

  assign upper_word = {upper_high_ff, upper_low_ff};
  assign lower_word = {lower_high_ff, lower_low_ff};
  assign new_word   = format_word(I_CONV.code, left_justify_ff, differential_ff);
  assign cur_word   = format_word(code_ff, left_justify_ff, differential_ff);
  assign do_write   = (wr_state_ff == WR_COLLECT) && aw_got_ff && w_got_ff;
  assign wr_sel     = decode(awaddr_ff);
  assign rd_sel     = decode(I_ARADDR);

  // ==========================================================================
  // Window compare, evaluated on each finished conversion.
  always_comb begin
    if (less_than(upper_word, lower_word, differential_ff)) begin
      window_hit = less_than(upper_word, new_word, differential_ff) &&
                   less_than(new_word, lower_word, differential_ff);
    end else begin
      window_hit = less_than(upper_word, new_word, differential_ff) ||
                   less_than(new_word, lower_word, differential_ff);
    end
  end

  // ==========================================================================
  // Register file and write channel.
  always_comb begin
    nxt_upper_low    = upper_low_ff;
    nxt_upper_high   = upper_high_ff;
    nxt_lower_low    = lower_low_ff;
    nxt_lower_high   = lower_high_ff;
    nxt_left_justify = left_justify_ff;
    nxt_differential = differential_ff;
    nxt_match        = match_ff;
    nxt_code         = code_ff;
    nxt_wr_state     = wr_state_ff;
    nxt_aw_got       = aw_got_ff;
    nxt_w_got        = w_got_ff;
    nxt_awaddr       = awaddr_ff;
    nxt_wbyte        = wbyte_ff;
    nxt_wlane        = wlane_ff;
    nxt_bvalid       = bvalid_ff;
    nxt_bresp        = bresp_ff;
    if (I_AWVALID && awready_ff) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = I_AWADDR;
    end
    if (I_WVALID && wready_ff) begin
      nxt_w_got = 1'b1;
      nxt_wbyte = I_WDATA[7:0];
      nxt_wlane = I_WSTRB[0];
    end
    case (wr_state_ff)
      WR_COLLECT: begin
        if (do_write) begin
          nxt_aw_got   = 1'b0;
          nxt_w_got    = 1'b0;
          nxt_bvalid   = 1'b1;
          nxt_bresp    = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
          nxt_wr_state = WR_RESP;
          if (wlane_ff) begin
            case (wr_sel)
              SEL_UPPER_LOW: nxt_upper_low  = wbyte_ff;
              SEL_UPPER_HI:  nxt_upper_high = wbyte_ff;
              SEL_LOWER_LOW: nxt_lower_low  = wbyte_ff;
              SEL_LOWER_HI:  nxt_lower_high = wbyte_ff;
              SEL_PAIR_CFG:  nxt_differential = wbyte_ff[PAIR_DIFFERENTIAL_BIT];
              SEL_CONTROL: begin
                nxt_left_justify = wbyte_ff[CTRL_LEFT_JUSTIFY_BIT];
                nxt_match        = wbyte_ff[CTRL_WINDOW_MATCH_BIT];
              end
              default: nxt_match = match_ff;
            endcase
          end
        end
      end
      WR_RESP: begin
        if (I_BREADY) begin
          nxt_bvalid   = 1'b0;
          nxt_wr_state = WR_COLLECT;
        end
      end
      default: nxt_wr_state = WR_COLLECT;
    endcase
    // A match in the same cycle as a software clear must not be lost.
    if (I_CONV.valid) begin
      nxt_code = I_CONV.code;
      if (window_hit) begin
        nxt_match = 1'b1;
      end
    end
    nxt_awready = !nxt_aw_got && (nxt_wr_state == WR_COLLECT);
    nxt_wready  = !nxt_w_got && (nxt_wr_state == WR_COLLECT);
  end

  // ==========================================================================
  // Read channel.
  always_comb begin
    nxt_rd_state = rd_state_ff;
    nxt_arready  = arready_ff;
    nxt_rvalid   = rvalid_ff;
    nxt_rdata    = rdata_ff;
    nxt_rresp    = rresp_ff;
    case (rd_state_ff)
      RD_IDLE: begin
        if (I_ARVALID) begin
          nxt_rd_state = RD_RESP;
          nxt_arready  = 1'b0;
          nxt_rvalid   = 1'b1;
          nxt_rresp    = RESP_OKAY;
          nxt_rdata    = 32'h00000000;
          if (rd_sel == SEL_PAIR_CFG) begin
            nxt_rdata[PAIR_DIFFERENTIAL_BIT] = differential_ff;
          end else if (rd_sel == SEL_RES_LOW) begin
            nxt_rdata[7:0] = cur_word[7:0];
          end else if (rd_sel == SEL_RES_HIGH) begin
            nxt_rdata[7:0] = cur_word[15:8];
          end else if (rd_sel == SEL_UPPER_LOW) begin
            nxt_rdata[7:0] = upper_low_ff;
          end else if (rd_sel == SEL_UPPER_HI) begin
            nxt_rdata[7:0] = upper_high_ff;
          end else if (rd_sel == SEL_LOWER_LOW) begin
            nxt_rdata[7:0] = lower_low_ff;
          end else if (rd_sel == SEL_LOWER_HI) begin
            nxt_rdata[7:0] = lower_high_ff;
          end else if (rd_sel == SEL_CONTROL) begin
            nxt_rdata[CTRL_LEFT_JUSTIFY_BIT] = left_justify_ff;
            nxt_rdata[CTRL_WINDOW_MATCH_BIT] = match_ff;
          end else begin
            nxt_rresp = RESP_SLVERR;
          end
        end
      end
      RD_RESP: begin
        if (I_RREADY) begin
          nxt_rd_state = RD_IDLE;
          nxt_arready  = 1'b1;
          nxt_rvalid   = 1'b0;
        end
      end
      default: nxt_rd_state = RD_IDLE;
    endcase
  end

  // ==========================================================================
  // Registers.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      upper_low_ff    <= RST_UPPER_LIMIT_LOW;
      upper_high_ff   <= RST_UPPER_LIMIT_HIGH;
      lower_low_ff    <= RST_LOWER_LIMIT_LOW;
      lower_high_ff   <= RST_LOWER_LIMIT_HIGH;
      left_justify_ff <= 1'b0;
      differential_ff <= 1'b0;
      match_ff        <= 1'b0;
      code_ff         <= 12'h000;
      wr_state_ff     <= WR_COLLECT;
      aw_got_ff       <= 1'b0;
      w_got_ff        <= 1'b0;
      awaddr_ff       <= '0;
      wbyte_ff        <= RST_BYTE_ZERO;
      wlane_ff        <= 1'b0;
      awready_ff      <= 1'b1;
      wready_ff       <= 1'b1;
      bvalid_ff       <= 1'b0;
      bresp_ff        <= RESP_OKAY;
      rd_state_ff     <= RD_IDLE;
      arready_ff      <= 1'b1;
      rvalid_ff       <= 1'b0;
      rdata_ff        <= 32'h00000000;
      rresp_ff        <= RESP_OKAY;
    end else begin
      upper_low_ff    <= nxt_upper_low;
      upper_high_ff   <= nxt_upper_high;
      lower_low_ff    <= nxt_lower_low;
      lower_high_ff   <= nxt_lower_high;
      left_justify_ff <= nxt_left_justify;
      differential_ff <= nxt_differential;
      match_ff        <= nxt_match;
      code_ff         <= nxt_code;
      wr_state_ff     <= nxt_wr_state;
      aw_got_ff       <= nxt_aw_got;
      w_got_ff        <= nxt_w_got;
      awaddr_ff       <= nxt_awaddr;
      wbyte_ff        <= nxt_wbyte;
      wlane_ff        <= nxt_wlane;
      awready_ff      <= nxt_awready;
      wready_ff       <= nxt_wready;
      bvalid_ff       <= nxt_bvalid;
      bresp_ff        <= nxt_bresp;
      rd_state_ff     <= nxt_rd_state;
      arready_ff      <= nxt_arready;
      rvalid_ff       <= nxt_rvalid;
      rdata_ff        <= nxt_rdata;
      rresp_ff        <= nxt_rresp;
    end
  end

  assign O_AWREADY      = awready_ff;
  assign O_WREADY       = wready_ff;
  assign O_BVALID       = bvalid_ff;
  assign O_BRESP        = bresp_ff;
  assign O_ARREADY      = arready_ff;
  assign O_RVALID       = rvalid_ff;
  assign O_RDATA        = rdata_ff;
  assign O_RRESP        = rresp_ff;
  assign O_WINDOW_MATCH = match_ff;

endmodule

// *** verification/adc_window_detector_props.sv ***
// Port-level assertions for the converter window detector.
module adc_window_detector_props
  import adc_window_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic                     I_CLK,
  input wire logic                     I_NRST,
  input wire adc_window_pkg::conv_type I_CONV,
  input wire logic                     I_BREADY,
  input wire logic                     I_ARVALID,
  input wire logic                     I_RREADY,
  input wire logic                     O_AWREADY,
  input wire logic                     O_WREADY,
  input wire logic [1:0]               O_BRESP,
  input wire logic                     O_BVALID,
  input wire logic                     O_ARREADY,
  input wire logic [31:0]              O_RDATA,
  input wire logic [1:0]               O_RRESP,
  input wire logic                     O_RVALID,
  input wire logic                     O_WINDOW_MATCH
);
  // ==========================================================================
  // Properties.
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // The flag only rises on a conversion or on the edge a control write lands.
  property p_match_set;
    $rose(O_WINDOW_MATCH) |-> $past(I_CONV.valid) || $rose(O_BVALID);
  endproperty
  a_match_set: assert property (p_match_set) else $error("Flag rose without cause.");
  property p_match_hold;
    $fell(O_WINDOW_MATCH) |-> $rose(O_BVALID);
  endproperty
  a_match_hold: assert property (p_match_hold) else $error("Flag fell without write.");
  property p_b_hold;
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("Write response dropped early.");
  property p_b_done;
    O_BVALID && I_BREADY |=> !O_BVALID ##1 (O_AWREADY && O_WREADY);
  endproperty
  a_b_done: assert property (p_b_done) else $error("Write channels not reopened.");
  property p_r_hold;
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("Read data dropped early.");
  property p_r_answer;
    I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("Read not answered next cycle.");
  property p_r_byte;
    O_RVALID |-> O_RDATA[31:8] == 24'h000000;
  endproperty
  a_r_byte: assert property (p_r_byte) else $error("Upper read bits not zero.");
  property p_r_err;
    O_RVALID && (O_RRESP == RESP_SLVERR) |-> O_RDATA == 32'h00000000;
  endproperty
  a_r_err: assert property (p_r_err) else $error("Error read carries data.");
  c_match: cover property ($rose(O_WINDOW_MATCH));
  c_clear: cover property ($fell(O_WINDOW_MATCH));
  c_err: cover property (O_RVALID && O_RRESP == RESP_SLVERR);
endmodule

bind adc_window_detector adc_window_detector_props #(.ADDR_W(ADDR_W)) u_props (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_CONV(I_CONV), .I_BREADY(I_BREADY),
  .I_ARVALID(I_ARVALID), .I_RREADY(I_RREADY), .O_AWREADY(O_AWREADY),
  .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .O_ARREADY(O_ARREADY),
  .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
  .O_WINDOW_MATCH(O_WINDOW_MATCH));

// *** verification/adc_window_detector_tb.sv ***
// Self-checking bench for the converter window detector.
module adc_window_detector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_window_pkg::*;
  // ==========================================================================
  // Signals and tables.
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  conv_type    conv = '0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        bready = 1'b0;
  logic        arv = 1'b0;
  logic        rready = 1'b0;
  logic        awr, wrdy, bv, arr, rv, flag;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          fail_count = 0;
  int          check_count = 0;
  logic [3:0]  wstrb = 4'hF;
  int          hold_off = 0;
  logic [11:0] ra [10] = '{12'h2E0, 12'h2F8, 12'h2FC, 12'h310, 12'h314, 12'h318, 12'h31C,
                           12'h3A0, 12'h004, 12'h311};
  logic [7:0]  rx [10] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [15:0] cu [6] = '{16'h0100, 16'h0100, 16'h0100, 16'h0200, 16'h0200, 16'h0200};
  logic [15:0] cl [6] = '{16'h0200, 16'h0200, 16'h0200, 16'h0100, 16'h0100, 16'h0100};
  logic [11:0] cc [6] = '{12'h150, 12'h200, 12'h100, 12'h201, 12'h200, 12'h0FF};

  adc_window_detector dut (
    .I_CLK(clk), .I_NRST(nrst), .I_CONV(conv), .I_AWADDR(awaddr), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wv), .O_WREADY(wrdy),
    .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rready),
    .O_WINDOW_MATCH(flag));

  // ==========================================================================
  // Tasks and models.
  task automatic end_of_test;
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Address and data go up together; each is dropped at its own handshake.
  task automatic bus_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= (hold_off == 0);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (n == hold_off) bready <= 1'b1;
    end while (!(bv === 1'b1 && bready === 1'b1) && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0, "write timeout");
  endtask

  task automatic bus_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= (hold_off == 0);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
      if (n == hold_off) rready <= 1'b1;
    end while (!(rv === 1'b1 && rready === 1'b1) && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0, "read timeout");
  endtask

  task automatic send(input logic [11:0] c);
    @(posedge clk);
    conv <= '{valid: 1'b1, code: c};
    @(posedge clk);
    conv.valid <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [15:0] fmt(input logic [11:0] c, input logic lj, input logic df);
    return lj ? {c, 4'h0} : (df ? {{4{c[11]}}, c} : {4'h0, c});
  endfunction

  // Limits compare as signed words when the input pair is differential.
  function automatic logic hit(input logic [15:0] w, input logic [15:0] u,
                               input logic [15:0] l, input logic df);
    logic signed [16:0] sw, su, sl;
    sw = {df & w[15], w};
    su = {df & u[15], u};
    sl = {df & l[15], l};
    return (su < sl) ? (su < sw && sw < sl) : (sw > su || sw < sl);
  endfunction

  // ==========================================================================
  // Clock, watchdog and main sequence.
  initial begin
    forever #12.5 clk = ~clk;
  end

  initial begin
    #1000000;
    fail_count++;
    $display("ERROR %0t watchdog timeout", $time);
    end_of_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] u, l, w;
    logic [11:0] c, c2;
    logic        lj, df, keep, ef;
    void'($urandom(12));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      bus_rd(ra[i], d, r);
      chk(d, {24'h000000, rx[i]}, "reset value");
      chk(32'(r), (i < 8) ? 32'(RESP_OKAY) : 32'(RESP_SLVERR), "read response");
    end
    // A write whose low byte lane is off must leave the limit byte untouched.
    wstrb <= 4'h0;
    bus_wr(12'h310, 8'h12, r);
    wstrb <= 4'hF;
    chk(32'(r), 32'(RESP_OKAY), "masked write response");
    bus_rd(12'h310, d, r);
    chk(d, {24'h000000, RST_UPPER_LIMIT_LOW}, "masked write");
    bus_wr(12'h004, 8'hAA, r);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped write");
    for (int i = 0; i < 48; i++) begin
      if (i < 6) begin
        u = cu[i];
        l = cl[i];
        c = cc[i];
        c2 = cc[i];
        lj = 1'b0;
        df = 1'b0;
        keep = 1'b0;
        hold_off = 0;
      end else begin
        u = 16'($urandom);
        l = 16'($urandom);
        c = 12'($urandom);
        c2 = 12'($urandom);
        lj = 1'($urandom);
        df = 1'($urandom);
        keep = 1'($urandom);
        hold_off = $urandom_range(3);
      end
      bus_wr(12'h2E0, {7'h00, df}, r);
      bus_wr(12'h3A0, {6'h00, keep, lj}, r);
      ef = keep;
      bus_wr(12'h310, u[7:0], r);
      bus_wr(12'h314, u[15:8], r);
      bus_wr(12'h318, l[7:0], r);
      bus_wr(12'h31C, l[15:8], r);
      chk(32'(r), 32'(RESP_OKAY), "limit write");
      send(c);
      ef = ef | hit(fmt(c, lj, df), u, l, df);
      chk(32'(flag), 32'(ef), "first match");
      send(c2);
      ef = ef | hit(fmt(c2, lj, df), u, l, df);
      chk(32'(flag), 32'(ef), "sticky match");
      w = fmt(c2, lj, df);
      bus_rd(12'h2FC, d, r);
      chk(d, {24'h000000, w[15:8]}, "result high");
      bus_rd(12'h2F8, d, r);
      chk(d, {24'h000000, w[7:0]}, "result low");
      bus_rd(12'h3A0, d, r);
      chk(d, {30'h0, ef, lj}, "control readback");
    end
    end_of_test();
  end
endmodule
